// ---- include/tcs_pkg.sv ----
package tcs_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 4;

  // register offsets
  localparam logic [3:0] OFS_MAIN_STATUS = 4'h0;
  localparam logic [3:0] OFS_SECONDARY_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  // field positions
  localparam int unsigned BIT_GR_A = 0;
  localparam int unsigned BIT_GR_B = 1;
  localparam int unsigned BIT_CMP = 0;
  localparam int unsigned BIT_OVF = 8;

  // irq event bit positions
  localparam int unsigned EV_GR_A = 0;
  localparam int unsigned EV_GR_B = 1;
  localparam int unsigned EV_CMP = 2;
  localparam int unsigned EV_OVF = 3;
  localparam int unsigned EV_N = 4;

  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [3:0] RST_EV = 4'h0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef struct packed {
    logic [15:0] main_counter;
    logic [15:0] secondary_counter;
    logic [15:0] general_reg_a;
    logic [15:0] general_reg_b;
    logic [15:0] output_compare_value;
    logic        gr_a_is_capture;
    logic        gr_b_is_capture;
    logic        capture_a;
    logic        capture_b;
  } tcs_timer_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tcs_bus_t;

endpackage : tcs_pkg

// ---- rtl/tcs_status_flags.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// R1: general-register-B flag sets when a capture copies the main counter into register B in capture mode.
// R2: general-register-B flag sets when the main counter equals register B in compare mode.
// R3: general-register-A flag, bit 0, sets when a capture copies the main counter into register A in capture mode.
// R4: general-register-A flag sets when the main counter equals register A in compare mode.
// R5: general-register-A flag clears only by a 0 write after it was read as 1, and resets to 0.
// R6: general-register-B flag, bit 1, clears the same read-then-write-0 way and resets to 0.
// R7: secondary status register is 16 bits, holds only overflow and compare match, and resets to 0.
// R8: secondary-overflow flag in bit 8 sets when the secondary counter wraps from all ones to zero.
// R9: secondary-overflow flag clears only by a 0 write after it was read as 1.
// R10: compare-match flag in bit 0 sets whenever the secondary counter equals the compare value.
// R11: compare-match flag clears by a 0 write after it was read as 1.
// R12: writing 0 to a flag only clears it; writing 1 never sets it.
// R13: reserved bits 15 to 9 and 7 to 1 of the secondary status register always read 0.
module tcs_status_flags
(
  input  wire logic                mclk,      // 50 MHz clock
  input  wire logic                reset_n,   // sync reset, active low
  input  wire tcs_pkg::tcs_timer_t tmr,       // counters, compares, captures
  input  wire tcs_pkg::tcs_bus_t   bus,       // register port request
  output logic [15:0]              rdata,     // read data, cycle after read
  output logic                     irq        // level interrupt
);
  import tcs_pkg::*;

  // event and flag bits share one layout: 0 gr_a, 1 gr_b, 2 cmp, 3 ovf
  logic [EV_N-1:0] ev;              // conditions seen this cycle
  logic [EV_N-1:0] rd_hit;          // flags read while set
  logic [EV_N-1:0] wr_zero;         // flags whose bit was written with zero
  wire  [EV_N-1:0] flag;            // documented flags, one cell each
  logic            gr_a_hit;
  logic            gr_b_hit;
  logic            cmp_hit;
  logic            sec_was_max;
  logic            sec_is_zero;
  logic            ovf_hit;
  logic [15:0]     prev_sec;
  logic [15:0]     next_prev_sec;
  logic            prev_valid;
  logic            next_prev_valid;
  logic            rd_main;
  logic            rd_sec;
  logic            rd_irq_st;
  logic            rd_irq_mask;
  logic            wr_main;
  logic            wr_sec;
  logic            wr_irq_st;
  logic            wr_irq_mask;
  logic [EV_N-1:0] ev_st;
  logic [EV_N-1:0] next_ev_st;
  logic [EV_N-1:0] ev_mask;
  logic [EV_N-1:0] next_ev_mask;
  logic [15:0]     main_view;
  logic [15:0]     sec_view;
  logic [15:0]     ev_st_view;
  logic [15:0]     ev_mask_view;
  logic [15:0]     next_rdata;

  // both general registers follow the same capture-or-compare rule, each on its own mode bit
  function automatic logic gr_event(input logic is_capture, input logic capture,
                                    input logic [15:0] counter, input logic [15:0] gr);
    if (is_capture)
    begin
      gr_event = capture;
    end
    else
    begin
      gr_event = (counter == gr);
    end
  endfunction : gr_event

  function automatic logic [15:0] main_word(input logic [EV_N-1:0] f);
    main_word = RST_STATUS;
    main_word[BIT_GR_A] = f[EV_GR_A];
    main_word[BIT_GR_B] = f[EV_GR_B];
  endfunction : main_word

  function automatic logic [15:0] sec_word(input logic [EV_N-1:0] f);
    sec_word = RST_STATUS;                       // [R13]
    sec_word[BIT_CMP] = f[EV_CMP];               // [R7]
    sec_word[BIT_OVF] = f[EV_OVF];               // [R7]
  endfunction : sec_word

  // interrupt status and mask share one layout, so one packing serves both
  function automatic logic [15:0] ev_word(input logic [EV_N-1:0] v);
    ev_word = RST_STATUS;
    ev_word[EV_N-1:0] = v;
  endfunction : ev_word

  always_comb
  begin
    gr_a_hit = gr_event(tmr.gr_a_is_capture, tmr.capture_a, tmr.main_counter, tmr.general_reg_a); // [R3] [R4]
    gr_b_hit = gr_event(tmr.gr_b_is_capture, tmr.capture_b, tmr.main_counter, tmr.general_reg_b); // [R1] [R2]

    // equality sets the flag on every cycle it holds, not only on arrival
    cmp_hit = (tmr.secondary_counter == tmr.output_compare_value);          // [R10]

    sec_was_max = (prev_sec == CNT_MAX);
    sec_is_zero = (tmr.secondary_counter == CNT_ZERO);
    // first cycle after reset has no history, so no wrap is inferred
    ovf_hit = prev_valid && sec_was_max && sec_is_zero;                     // [R8]

    ev = RST_EV;
    ev[EV_GR_A] = gr_a_hit;
    ev[EV_GR_B] = gr_b_hit;
    ev[EV_CMP] = cmp_hit;
    ev[EV_OVF] = ovf_hit;
  end

  // one cycle of counter history is enough to see the wrap
  always_comb
  begin
    next_prev_sec = tmr.secondary_counter;
    next_prev_valid = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      prev_sec <= RST_STATUS;
      prev_valid <= 1'b0;
    end
    else
    begin
      prev_sec <= next_prev_sec;
      prev_valid <= next_prev_valid;
    end
  end

  // only the addressed register's strobes can be high; unmapped offsets decode to nothing
  always_comb
  begin
    rd_main = 1'b0;
    rd_sec = 1'b0;
    rd_irq_st = 1'b0;
    rd_irq_mask = 1'b0;
    wr_main = 1'b0;
    wr_sec = 1'b0;
    wr_irq_st = 1'b0;
    wr_irq_mask = 1'b0;
    case (bus.addr)
      OFS_MAIN_STATUS:
      begin
        rd_main = bus.rd;
        wr_main = bus.wr;
      end

      OFS_SECONDARY_STATUS:
      begin
        rd_sec = bus.rd;
        wr_sec = bus.wr;
      end

      OFS_IRQ_STATUS:
      begin
        rd_irq_st = bus.rd;
        wr_irq_st = bus.wr;
      end

      OFS_IRQ_MASK:
      begin
        rd_irq_mask = bus.rd;
        wr_irq_mask = bus.wr;
      end

      default:
      begin
        rd_main = 1'b0;
      end
    endcase
  end

  // a read arms only the flags that are set at that moment
  always_comb
  begin
    rd_hit = RST_EV;
    wr_zero = RST_EV;
    if (rd_main)
    begin
      rd_hit[EV_GR_A] = flag[EV_GR_A];
      rd_hit[EV_GR_B] = flag[EV_GR_B];
    end
    if (rd_sec)
    begin
      rd_hit[EV_CMP] = flag[EV_CMP];
      rd_hit[EV_OVF] = flag[EV_OVF];
    end

    // a one in a flag's bit is ignored, so software can never set a flag
    if (wr_main)
    begin
      wr_zero[EV_GR_A] = ~bus.wdata[BIT_GR_A];   // [R12]
      wr_zero[EV_GR_B] = ~bus.wdata[BIT_GR_B];   // [R12]
    end
    if (wr_sec)
    begin
      wr_zero[EV_CMP] = ~bus.wdata[BIT_CMP];     // [R12]
      wr_zero[EV_OVF] = ~bus.wdata[BIT_OVF];     // [R12]
    end
  end

  // one cell per flag; a new event in the clearing cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < EV_N; gi = gi + 1)
    begin : g_flag
      logic bit_flag;
      logic next_bit_flag;
      logic bit_armed;
      logic next_bit_armed;

      always_comb
      begin
        next_bit_flag = bit_flag;
        next_bit_armed = bit_armed;

        // a zero write without the earlier read leaves the flag alone
        if (wr_zero[gi] && bit_armed)
        begin
          next_bit_flag = 1'b0;                  // [R5] [R6] [R9] [R11]
          next_bit_armed = 1'b0;
        end
        if (rd_hit[gi])
        begin
          next_bit_armed = 1'b1;
        end

        // a cleared flag must be read again before the next clear counts
        if (!next_bit_flag)
        begin
          next_bit_armed = 1'b0;
        end
        if (ev[gi])
        begin
          next_bit_flag = 1'b1;
        end
      end

      always_ff @(posedge mclk)
      begin
        if (!reset_n)
        begin
          bit_flag <= RST_EV[gi];                // [R5] [R6] [R7]
          bit_armed <= RST_EV[gi];
        end
        else
        begin
          bit_flag <= next_bit_flag;
          bit_armed <= next_bit_armed;
        end
      end

      assign flag[gi] = bit_flag;
    end
  endgenerate

  // the interrupt status keeps its own copy, so clearing a flag leaves it pending
  always_comb
  begin
    next_ev_st = ev_st | ev;
    next_ev_mask = ev_mask;
    if (wr_irq_st)
    begin
      next_ev_st = (ev_st & ~bus.wdata[EV_N-1:0]) | ev;
    end
    if (wr_irq_mask)
    begin
      next_ev_mask = bus.wdata[EV_N-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ev_st <= RST_EV;
      ev_mask <= RST_EV;
    end
    else
    begin
      ev_st <= next_ev_st;
      ev_mask <= next_ev_mask;
    end
  end

  assign irq = |(ev_st & ev_mask);

  // word views of every readable register
  always_comb
  begin
    main_view = main_word(flag);
    sec_view = sec_word(flag);                   // [R13]
    ev_st_view = ev_word(ev_st);
    ev_mask_view = ev_word(ev_mask);
  end

  // rdata falls back to zero after its one cycle so stale words never linger
  always_comb
  begin
    next_rdata = RST_STATUS;
    if (rd_main)
    begin
      next_rdata = main_view;
    end
    if (rd_sec)
    begin
      next_rdata = sec_view;                     // [R13]
    end
    if (rd_irq_st)
    begin
      next_rdata = ev_st_view;
    end
    if (rd_irq_mask)
    begin
      next_rdata = ev_mask_view;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rdata <= RST_STATUS;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

endmodule : tcs_status_flags

// ---- testbench/tcs_status_flags_assertions.sv ----
`timescale 1ns/10ps
module tcs_status_flags_assertions
  import tcs_pkg::*;
(
  input wire logic                mclk,    // clock
  input wire logic                reset_n, // reset
  input wire tcs_pkg::tcs_timer_t tmr,     // timer
  input wire tcs_pkg::tcs_bus_t   bus,     // bus
  input wire logic [15:0]         rdata,   // read data
  input wire logic                irq      // interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // a write in the gap could legally clear, so only quiet gaps count
  wire g = !bus.wr;
  wire rm = bus.rd && bus.addr == OFS_MAIN_STATUS;
  wire rs = bus.rd && bus.addr == OFS_SECONDARY_STATUS;
  property p_b_cap; tmr.capture_b && tmr.gr_b_is_capture ##1 g ##1 rm |=> rdata[1]; endproperty
  a_b_cap: assert property (p_b_cap) else $error("b cap");
  property p_b_cmp; !tmr.gr_b_is_capture && tmr.main_counter == tmr.general_reg_b ##1 g ##1 rm |=> rdata[1]; endproperty
  a_b_cmp: assert property (p_b_cmp) else $error("b cmp");
  property p_a_cap; tmr.capture_a && tmr.gr_a_is_capture ##1 g ##1 rm |=> rdata[0]; endproperty
  a_a_cap: assert property (p_a_cap) else $error("a cap");
  property p_a_cmp; !tmr.gr_a_is_capture && tmr.main_counter == tmr.general_reg_a ##1 g ##1 rm |=> rdata[0]; endproperty
  a_a_cmp: assert property (p_a_cmp) else $error("a cmp");
  property p_ovf; $past(reset_n) && $past(tmr.secondary_counter) == CNT_MAX && tmr.secondary_counter == CNT_ZERO
    ##1 rs |=> rdata[8]; endproperty
  a_ovf: assert property (p_ovf) else $error("ovf");
  property p_cmp; tmr.secondary_counter == tmr.output_compare_value ##1 g ##1 rs |=> rdata[0]; endproperty
  a_cmp: assert property (p_cmp) else $error("cmp");
  property p_resv; rs |=> rdata[15:9] == 7'h00 && rdata[7:1] == 7'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved");
  property p_idle; !bus.rd |=> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("idle rdata");
endmodule : tcs_status_flags_assertions
bind tcs_status_flags tcs_status_flags_assertions chk_i (.mclk(mclk), .reset_n(reset_n), .tmr(tmr),
  .bus(bus), .rdata(rdata), .irq(irq));

// ---- testbench/tcs_status_flags_bench.sv ----
`timescale 1ns/10ps
module tcs_status_flags_bench;
  import tcs_pkg::*;
  logic        mclk = 1'b0, reset_n = 1'b0, irq;
  logic [15:0] rdata;
  tcs_timer_t  tmr, idl, t;
  tcs_bus_t    bus = '0;
  int          mismatches = 0, comparisons = 0;
  tcs_status_flags dut (.mclk(mclk), .reset_n(reset_n), .tmr(tmr), .bus(bus), .rdata(rdata), .irq(irq));
  initial forever #10 mclk = ~mclk;
  task chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus <= '0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk) bus <= '0;
    #1 chk("rdata", rdata, e);
  endtask : rd
  task ev(input tcs_timer_t v);
    @(posedge mclk) tmr <= v;
    @(posedge mclk) tmr <= idl;
  endtask : ev
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial
  begin
    // idle secondary count of zero lets one cycle at all ones make the wrap
    idl = '{16'h0001, 16'h0000, 16'h0003, 16'h0004, 16'h0005, 1'b1, 1'b1, 1'b0, 1'b0};
    tmr = idl;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFS_MAIN_STATUS, 16'h0000);
    rd(OFS_SECONDARY_STATUS, 16'h0000);
    rd(4'h2, 16'h0000);
    $display("reset test done");
    t = idl;
    t.secondary_counter = 16'h0005;
    ev(t);
    rd(OFS_SECONDARY_STATUS, 16'h0001);
    wr(OFS_SECONDARY_STATUS, 16'h0101);
    rd(OFS_SECONDARY_STATUS, 16'h0001);
    wr(OFS_SECONDARY_STATUS, 16'h0000);
    rd(OFS_SECONDARY_STATUS, 16'h0000);
    ev(t);
    wr(OFS_SECONDARY_STATUS, 16'h0000);
    rd(OFS_SECONDARY_STATUS, 16'h0001);
    t.secondary_counter = CNT_MAX;
    ev(t);
    rd(OFS_SECONDARY_STATUS, 16'h0101);
    wr(OFS_SECONDARY_STATUS, 16'h0000);
    rd(OFS_SECONDARY_STATUS, 16'h0000);
    $display("secondary test done");
    wr(OFS_IRQ_STATUS, 16'h000F);
    wr(OFS_IRQ_MASK, 16'h000F);
    t = idl;
    t.capture_a = 1'b1;
    t.gr_b_is_capture = 1'b0;
    t.main_counter = 16'h0004;
    ev(t);
    #1 chk("irq", {15'h0000, irq}, 16'h0001);
    rd(OFS_MAIN_STATUS, 16'h0003);
    rd(OFS_IRQ_STATUS, 16'h0003);
    wr(OFS_MAIN_STATUS, 16'h0000);
    rd(OFS_MAIN_STATUS, 16'h0000);
    t = idl;
    t.capture_b = 1'b1;
    t.gr_a_is_capture = 1'b0;
    t.main_counter = 16'h0003;
    ev(t);
    rd(OFS_MAIN_STATUS, 16'h0003);
    wr(OFS_IRQ_MASK, 16'h0000);
    #1 chk("irq", {15'h0000, irq}, 16'h0000);
    wr(OFS_IRQ_STATUS, 16'h000F);
    wr(OFS_IRQ_MASK, 16'h000F);
    #1 chk("irq", {15'h0000, irq}, 16'h0000);
    $display("main test done");
    end_of_test;
  end
  initial
  begin
    repeat (1000) @(posedge mclk);
    mismatches++;
    end_of_test;
  end
endmodule : tcs_status_flags_bench
